//--- fsp_map.vh
// Constants for the flash self-program sequencer: offsets, fields, patterns, timing
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSP_CTRL_OFS        4'h0
`define FSP_STAT_OFS        4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FSP_EN_BIT          0
`define FSP_ERASE_BIT       1
`define FSP_WRITE_BIT       2
`define FSP_LOCKSEL_BIT     3
`define FSP_RWWRE_BIT       4
`define FSP_RWWBUSY_BIT     6
`define FSP_IRQEN_BIT       7
`define FSP_CTRL_RESET      8'h00

// ----------------------------------------------------------------
// Command patterns, control bits 5:0 (bit 7 is a don't care)
// ----------------------------------------------------------------
`define FSP_CMD_LOAD        6'h01
`define FSP_CMD_ERASE       6'h03
`define FSP_CMD_WRITE       6'h05
`define FSP_CMD_LOCK        6'h09
`define FSP_CMD_RWWRE       6'h11
`define FSP_CMD_NONE        6'h00

// ----------------------------------------------------------------
// Pointer split: byte pointer -> word in page, page
// ----------------------------------------------------------------
`define FSP_WORD_LSB        1
`define FSP_WORD_MSB        6
`define FSP_PAGE_LSB        7
`define FSP_PAGE_MSB        14
`define FSP_PAGE_WORDS      64
`define FSP_LAST_WORD       6'h3f

// ----------------------------------------------------------------
// Flash map (word addresses) and reset values
// ----------------------------------------------------------------
`define FSP_FLASH_WORDS     16384
`define FSP_NO_READ_WHILE_WRITE_REGION_PAGE       8'he0
`define FSP_APP_RESET       14'h0000
`define FSP_BOOT_RESET      14'h3800
`define FSP_LOCK_RESET      6'h3f
`define FSP_ERASED_WORD     16'hffff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSP_CMD_WINDOW      3'h4
`define FSP_PROG_CYCLES     64

`endif

//--- fsp_sequencer.v
// Flash self-program sequencer with AXI4-Lite control and core store port
`timescale 1ns/1ps
`include "fsp_map.vh"

module fsp_sequencer #(
	parameter PROG_CYCLES = `FSP_PROG_CYCLES
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Core store instruction
	input  wire        core_store,
	input  wire [15:0] core_pointer,
	input  wire [15:0] core_data_pair,
	// Core program-memory load
	input  wire        core_load,
	input  wire [15:0] core_load_pointer,
	output reg  [7:0]  core_load_data,
	output reg         core_load_blocked,
	// Core control
	output reg         core_halt,
	output reg  [13:0] reset_vector,
	output reg         spm_irq,
	output reg  [5:0]  lock_bits,
	// EEPROM activity and fuse pin
	input  wire        eeprom_write,
	input  wire        boot_reset_select_fuse
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam ST_IDLE   = 2'b00;
	localparam ST_ARMED  = 2'b01;
	localparam ST_PAGE   = 2'b10;
	localparam ST_SETTLE = 2'b11;
	localparam [15:0] PROG_LEN = PROG_CYCLES;

	reg [1:0]  st;
	reg [5:0]  cmd;
	reg        irq_en;
	reg        rww_busy_flag;
	reg [2:0]  win;
	reg [15:0] cnt;
	reg [5:0]  idx;
	reg [7:0]  op_page;
	reg        op_write;
	reg [`FSP_PAGE_WORDS-1:0] slot_valid;
	reg        fuse_s1;
	reg        fuse_s2;

	reg [15:0] flash_mem  [0:`FSP_FLASH_WORDS-1];
	reg [15:0] page_buf   [0:`FSP_PAGE_WORDS-1];

	// Bus bookkeeping
	reg        aw_held;
	reg        w_held;
	reg [3:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg        next_aw_held;
	reg        next_w_held;
	reg        next_bvalid;
	reg        next_rvalid;
	reg        wr_fire;
	reg [31:0] rd_word;
	reg [1:0]  rd_resp;

	wire       ctrl_wr  = wr_fire && (aw_addr == `FSP_CTRL_OFS) && w_strb[0];
	wire [5:0] wr_cmd   = w_data[5:0];
	wire       cmd_ok   = (wr_cmd == `FSP_CMD_LOAD) || (wr_cmd == `FSP_CMD_ERASE) ||
		(wr_cmd == `FSP_CMD_WRITE) || (wr_cmd == `FSP_CMD_LOCK) ||
		(wr_cmd == `FSP_CMD_RWWRE);
	wire       exec     = (st == ST_ARMED) && core_store && (win != 3'h0);
	wire [5:0] z_word   = core_pointer[`FSP_WORD_MSB:`FSP_WORD_LSB];
	wire [7:0] z_page   = core_pointer[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
	wire       busy     = (st != ST_IDLE);
	wire       buf_we   = exec && (cmd == `FSP_CMD_LOAD);
	// Slot of a load that meets an EEPROM write in the same cycle
	wire [`FSP_PAGE_WORDS-1:0] load_onehot = {{(`FSP_PAGE_WORDS-1){1'b0}}, 1'b1} << z_word;
	wire       mem_we   = (st == ST_PAGE);
	wire [15:0] mem_wd  = (op_write && slot_valid[idx]) ? page_buf[idx] : `FSP_ERASED_WORD;
	wire [7:0] ld_page  = core_load_pointer[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
	wire       ld_rww   = ld_page < `FSP_NO_READ_WHILE_WRITE_REGION_PAGE;

	// ----------------------------------------------------------------
	// Bus handshake next values
	// ----------------------------------------------------------------
	always @* begin
		wr_fire      = aw_held && w_held && !s_axi_bvalid;
		next_aw_held = (aw_held && !wr_fire) || (s_axi_awvalid && s_axi_awready);
		next_w_held  = (w_held && !wr_fire) || (s_axi_wvalid && s_axi_wready);
		next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
		next_rvalid  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
		rd_resp      = 2'b00;
		if (s_axi_araddr == `FSP_CTRL_OFS) begin
			rd_word = {24'h000000, irq_en, rww_busy_flag, 1'b0, cmd[4:1], busy};
		end else if (s_axi_araddr == `FSP_STAT_OFS) begin
			rd_word = {20'h00000, core_halt, rww_busy_flag, busy, fuse_s2, 2'b00, lock_bits};
		end else begin
			rd_word = 32'h00000000;
			rd_resp = 2'b10;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= 32'h00000000;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_axi_bvalid  <= next_bvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				if (aw_addr == `FSP_CTRL_OFS || aw_addr == `FSP_STAT_OFS) begin
					s_axi_bresp <= 2'b00;
				end else begin
					s_axi_bresp <= 2'b10;
				end
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_resp;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fuse pin and reset vector
	// ----------------------------------------------------------------
	// Fuse is sampled, never written: no store path reaches it
	always @(posedge aclk) begin
		if (!aresetn) begin
			fuse_s1      <= 1'b1;
			fuse_s2      <= 1'b1;
			reset_vector <= `FSP_APP_RESET;
		end else begin
			fuse_s1      <= boot_reset_select_fuse;
			fuse_s2      <= fuse_s1;
			reset_vector <= fuse_s2 ? `FSP_APP_RESET : `FSP_BOOT_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			st            <= ST_IDLE;
			cmd           <= `FSP_CMD_NONE;
			irq_en        <= 1'b0;
			rww_busy_flag <= 1'b0;
			win           <= 3'h0;
			cnt           <= 16'h0000;
			idx           <= 6'h00;
			op_page       <= 8'h00;
			op_write      <= 1'b0;
			slot_valid    <= {`FSP_PAGE_WORDS{1'b0}};
			lock_bits     <= `FSP_LOCK_RESET;
			core_halt     <= 1'b0;
			spm_irq       <= 1'b0;
		end else begin
			spm_irq <= irq_en && !busy;
			if (ctrl_wr) begin
				irq_en <= w_data[`FSP_IRQEN_BIT];
			end
			// Set wins: a load in the discard cycle keeps only its own slot
			if (eeprom_write && (|slot_valid)) begin
				slot_valid <= buf_we ? load_onehot : {`FSP_PAGE_WORDS{1'b0}};
			end else if (buf_we) begin
				slot_valid[z_word] <= 1'b1;
			end
			case (st)
			ST_ARMED: begin
				win <= win - 3'h1;
				if (exec) begin
					win <= 3'h0;
					if (cmd == `FSP_CMD_ERASE || cmd == `FSP_CMD_WRITE) begin
						op_page       <= z_page;
						op_write      <= (cmd == `FSP_CMD_WRITE);
						idx           <= 6'h00;
						rww_busy_flag <= 1'b1;
						core_halt     <= (z_page >= `FSP_NO_READ_WHILE_WRITE_REGION_PAGE);
						st            <= ST_PAGE;
					end else if (cmd == `FSP_CMD_LOCK) begin
						lock_bits <= lock_bits & core_data_pair[5:0];
						cnt       <= PROG_LEN;
						st        <= ST_SETTLE;
					end else if (cmd == `FSP_CMD_RWWRE) begin
						rww_busy_flag <= 1'b0;
						slot_valid    <= {`FSP_PAGE_WORDS{1'b0}};
						cmd           <= `FSP_CMD_NONE;
						st            <= ST_IDLE;
					end else begin
						cmd <= `FSP_CMD_NONE;
						st  <= ST_IDLE;
					end
				end else if (win == 3'h1) begin
					cmd <= `FSP_CMD_NONE;
					st  <= ST_IDLE;
				end
			end
			ST_PAGE: begin
				idx <= idx + 6'h01;
				if (idx == `FSP_LAST_WORD) begin
					cnt <= PROG_LEN;
					st  <= ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				cnt <= cnt - 16'h0001;
				if (cnt <= 16'h0001) begin
					st        <= ST_IDLE;
					cmd       <= `FSP_CMD_NONE;
					core_halt <= 1'b0;
					op_write  <= 1'b0;
					// Busy flag stays set until software re-enables the region
					if (op_write) begin
						slot_valid <= {`FSP_PAGE_WORDS{1'b0}};
					end
				end
			end
			default: begin
				win <= 3'h0;
				// Arming only from idle; writes while busy only touch the interrupt enable
				if (ctrl_wr && w_data[`FSP_EN_BIT] && cmd_ok) begin
					st  <= ST_ARMED;
					cmd <= wr_cmd;
					win <= `FSP_CMD_WINDOW;
				end
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Page buffer and flash array
	// ----------------------------------------------------------------
	// One word per cycle keeps a single write port on the array
	always @(posedge aclk) begin
		if (buf_we) begin
			page_buf[z_word] <= core_data_pair;
		end
		if (mem_we) begin
			flash_mem[{op_page, idx}] <= mem_wd;
		end
	end

	// ----------------------------------------------------------------
	// Program-memory load port
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			core_load_data    <= 8'h00;
			core_load_blocked <= 1'b0;
		end else if (core_load) begin
			if (rww_busy_flag && ld_rww) begin
				core_load_data    <= 8'h00;
				core_load_blocked <= 1'b1;
			end else if (core_load_pointer[0]) begin
				core_load_data    <= flash_mem[core_load_pointer[14:1]][15:8];
				core_load_blocked <= 1'b0;
			end else begin
				core_load_data    <= flash_mem[core_load_pointer[14:1]][7:0];
				core_load_blocked <= 1'b0;
			end
		end
	end

endmodule // fsp_sequencer

//--- fsp_sequencer_properties.sv
// Port-level checks for the flash self-program sequencer
`timescale 1ns/1ps

module fsp_sequencer_chk (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Write channels
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	// Core side
	input logic        core_store,
	input logic [7:0]  core_load_data,
	input logic        core_load_blocked,
	input logic        core_halt,
	input logic        spm_irq,
	input logic [5:0]  lock_bits,
	input logic [13:0] reset_vector,
	input logic        boot_reset_select_fuse
);
	default clocking dck @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !core_halt
		&& !spm_irq && lock_bits == 6'h3f) else $error("outputs not cleared by reset");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
	resp_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
	ready_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
	halt_start_a: assert property ($rose(core_halt) |-> $past(core_store))
		else $error("halt without store");
	halt_long_a: assert property ($rose(core_halt) |=> core_halt [*8])
		else $error("halt released early");
	load_block_a: assert property (core_load_blocked |-> core_load_data == 8'h00)
		else $error("blocked load returned data");
	vector_app_a: assert property (boot_reset_select_fuse [*5] |-> reset_vector == 14'h0000)
		else $error("wrong application reset vector");
	vector_boot_a: assert property (!boot_reset_select_fuse [*5] |-> reset_vector == 14'h3800)
		else $error("wrong boot reset vector");
	lock_fall_a: assert property ($past(aresetn) |-> (lock_bits & ~$past(lock_bits)) == 6'h00)
		else $error("lock bit returned to one");

	cover property ($rose(core_halt));
	cover property (core_load_blocked);
	cover property ($fell(spm_irq));
endmodule // fsp_sequencer_chk

bind fsp_sequencer fsp_sequencer_chk i_fsp_sequencer_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .core_store,
	.core_load_data, .core_load_blocked, .core_halt, .spm_irq, .lock_bits, .reset_vector,
	.boot_reset_select_fuse);

//--- fsp_core_model.sv
// Behavioural processor core issuing program-memory stores and loads
`timescale 1ns/1ps

module fsp_core_model (
	// Clock
	input  logic        aclk,
	// Store instruction
	output logic        core_store,
	output logic [15:0] core_pointer,
	output logic [15:0] core_data_pair,
	// Program-memory load
	output logic        core_load,
	output logic [15:0] core_load_pointer,
	input  logic [7:0]  core_load_data,
	input  logic        core_load_blocked
);
	initial begin
		{core_store, core_load} = 2'b00;
		{core_pointer, core_data_pair, core_load_pointer} = 48'h0;
	end

	// ----------------------------------------------------------------
	// Instructions
	// ----------------------------------------------------------------
	// Operands flip once taken, so an unlatched address shows up
	task automatic store(input logic [15:0] p, input logic [15:0] d);
		core_store <= 1'b1;
		core_pointer <= p;
		core_data_pair <= d;
		@(posedge aclk);
		core_store <= 1'b0;
		core_pointer <= ~p;
		core_data_pair <= ~d;
	endtask

	task automatic fetch(input logic [15:0] p, output logic [7:0] b, output logic k);
		core_load <= 1'b1;
		core_load_pointer <= p;
		@(posedge aclk);
		core_load <= 1'b0;
		core_load_pointer <= ~p;
		@(posedge aclk);
		b = core_load_data;
		k = core_load_blocked;
	endtask
endmodule // fsp_core_model

//--- test_fsp_sequencer.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
`include "fsp_map.vh"

module test_fsp_sequencer;
	logic        aclk = 1'b0, aresetn = 1'b0, eeprom_write = 1'b0, boot_reset_select_fuse = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, word_got;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, blk;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        core_store, core_load, core_load_blocked, core_halt, spm_irq;
	logic [15:0] core_pointer, core_data_pair, core_load_pointer;
	logic [7:0]  core_load_data, byte_got;
	logic [13:0] reset_vector;
	logic [5:0]  lock_bits;
	int          err_total = 0, tests_run = 0, cycles = 0;
	// Pointer, expected byte; slot 1 never loaded so it reads erased
	logic [23:0] rows [7] = '{24'h008034, 24'h008112, 24'h00865c, 24'h00873a,
		24'h0084ef, 24'h0085be, 24'h0082ff};

	always #10 aclk = ~aclk;

	fsp_sequencer #(.PROG_CYCLES(4)) i_fsp_sequencer (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_store, .core_pointer,
		.core_data_pair, .core_load, .core_load_pointer, .core_load_data, .core_load_blocked,
		.core_halt, .reset_vector, .spm_irq, .lock_bits, .eeprom_write, .boot_reset_select_fuse);
	fsp_core_model i_fsp_core_model (.aclk, .core_store, .core_pointer, .core_data_pair,
		.core_load, .core_load_pointer, .core_load_data, .core_load_blocked);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Interrupt enable rides along so spm_irq marks completion
	task automatic spm_go(input logic [5:0] c, input logic [15:0] p, input logic [15:0] d);
		axw(`FSP_CTRL_OFS, {24'h0, 2'b10, c}, rsp);
		i_fsp_core_model.store(p, d);
	endtask

	task automatic spm_wait();
		repeat (2) @(posedge aclk);
		while (spm_irq !== 1'b1) @(posedge aclk);
	endtask

	task automatic spm(input logic [5:0] c, input logic [15:0] p, input logic [15:0] d);
		spm_go(c, p, d);
		spm_wait();
	endtask

	task automatic ld(input logic [15:0] p, input logic [7:0] e, input logic k);
		i_fsp_core_model.fetch(p, byte_got, blk);
		chk({blk, byte_got}, {k, e});
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge aclk);
		chk({s_axi_bvalid, core_halt, spm_irq, lock_bits}, 32'h3f);
		chk(32'(reset_vector), 32'h0);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(32'(reset_vector), 32'h0);
		spm(`FSP_CMD_LOAD, 16'h0086, 16'h3a5c);
		spm(`FSP_CMD_LOAD, 16'h0080, 16'h1234);
		spm(`FSP_CMD_LOAD, 16'h0084, 16'hbeef);
		spm(`FSP_CMD_ERASE, 16'h00bf, 16'h5a5a);
		spm(`FSP_CMD_WRITE, 16'h0080, 16'h5a5a);
		rd(`FSP_STAT_OFS, word_got, rsp);
		chk(word_got & 32'h400, 32'h400);
		ld(16'h0080, 8'h00, 1'b1);
		spm(`FSP_CMD_RWWRE, 16'h0000, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			ld(rows[i][23:8], rows[i][7:0], 1'b0);
		end
		spm(`FSP_CMD_LOAD, 16'h0100, 16'h5555);
		eeprom_write <= 1'b1;
		@(posedge aclk);
		eeprom_write <= 1'b0;
		spm(`FSP_CMD_ERASE, 16'h0100, 16'h0000);
		spm(`FSP_CMD_WRITE, 16'h0100, 16'h0000);
		spm(`FSP_CMD_RWWRE, 16'h0000, 16'h0000);
		ld(16'h0100, 8'hff, 1'b0);
		ld(16'h0106, 8'hff, 1'b0);
		spm_go(`FSP_CMD_ERASE, 16'h7000, 16'h0000);
		repeat (4) @(posedge aclk);
		chk({core_halt, spm_irq}, 32'h2);
		spm_wait();
		chk(32'(core_halt), 32'h0);
		// Boot write lock (data bit 4) programmed along with data bits 2 and 3
		spm(`FSP_CMD_LOCK, 16'hffff, 16'h00e3);
		chk(32'(lock_bits), 32'h23);
		axw(`FSP_CTRL_OFS, 32'h89, rsp);
		repeat (6) @(posedge aclk);
		i_fsp_core_model.store(16'h0180, 16'h0000);
		rd(`FSP_CTRL_OFS, word_got, rsp);
		chk(word_got & 32'h9, 32'h0);
		chk(32'(lock_bits), 32'h23);
		chk(32'(spm_irq), 32'h1);
		axw(4'h8, 32'h0, rsp);
		chk(32'(rsp), 32'h2);
		rd(4'hc, word_got, rsp);
		chk({word_got[29:0], rsp}, 32'h2);
		boot_reset_select_fuse <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(32'(reset_vector), 32'h3800);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		chk({lock_bits, reset_vector}, 32'hff800);
		conclude();
	end
endmodule // test_fsp_sequencer
